//--- include/fcled_pkg.sv
// Shared constants, register map and defaults of the four channel LED driver
package fcled_pkg;
  localparam int CLK_HZ           = 50_000_000;
  localparam int OSC_HZ           = 400_000;
  localparam int OSC_TICK_CYC     = CLK_HZ / OSC_HZ;
  localparam int GDIM_HZ          = 190;
  localparam int GDIM_STEPS       = 16;
  localparam int GDIM_STEP_TICKS  = OSC_HZ / (GDIM_HZ * GDIM_STEPS);
  localparam int BLINK_MAX_HZ     = 24;
  localparam int BLINK_STEPS      = 256;
  localparam int BLINK_STEP_TICKS = OSC_HZ / (BLINK_MAX_HZ * BLINK_STEPS);
  // Group frequency settings up to this value give 6 Hz or faster
  localparam logic [7:0] BLINK_COARSE_MAX = 8'h03;
  localparam logic [7:0] COARSE_MASK      = 8'hFC;

  localparam logic [3:0] REG_MODE1  = 4'h0;
  localparam logic [3:0] REG_MODE2  = 4'h1;
  localparam logic [3:0] REG_BRIGHT = 4'h2;
  localparam logic [3:0] REG_GDUTY  = 4'h6;
  localparam logic [3:0] REG_GFREQ  = 4'h7;
  localparam logic [3:0] REG_STATE  = 4'h8;
  localparam logic [3:0] REG_SUB1   = 4'h9;
  localparam logic [3:0] REG_GCALL  = 4'hC;
  localparam logic [3:0] REG_LAST   = 4'hC;
  localparam int         REG_CNT    = 13;
  localparam int         CFG_CNT    = 8;

  localparam int M1_GCALL_EN_BIT = 0;
  localparam int M1_SUB1_EN_BIT  = 1;
  localparam int M2_PUSHPULL_BIT = 2;
  localparam int M2_UPD_ACK_BIT  = 3;
  localparam int M2_BLINK_BIT    = 5;
  localparam int CTRL_ADV_EN_BIT = 7;

  localparam logic [7:0] MODE1_RST  = 8'h01;
  localparam logic [7:0] MODE2_RST  = 8'h04;
  localparam logic [7:0] BRIGHT_RST = 8'h00;
  localparam logic [7:0] GDUTY_RST  = 8'hFF;
  localparam logic [7:0] GFREQ_RST  = 8'h00;
  localparam logic [7:0] STATE_RST  = 8'h00;
  localparam logic [7:0] SUB1_RST   = 8'hE2;
  localparam logic [7:0] SUB2_RST   = 8'hE4;
  localparam logic [7:0] SUB3_RST   = 8'hE8;
  localparam logic [7:0] GCALL_RST  = 8'hE0;
  localparam logic [6:0] SOFT_RESET_ADDR = 7'h03;

  localparam logic [1:0] OUT_OFF  = 2'h0;
  localparam logic [1:0] OUT_ON   = 2'h1;
  localparam logic [1:0] OUT_IND  = 2'h2;
  localparam logic [1:0] OUT_BOTH = 2'h3;

  typedef enum {LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_WR, LK_WR_ACK, LK_RD, LK_RD_ACK} fcled_link_e;

  function automatic logic [7:0] fcled_rst_val(input logic [3:0] idx);
    unique case (idx)
      REG_MODE1:                   return MODE1_RST;
      REG_MODE2:                   return MODE2_RST;
      4'h2, 4'h3, 4'h4, 4'h5:      return BRIGHT_RST;
      REG_GDUTY:                   return GDUTY_RST;
      REG_GFREQ:                   return GFREQ_RST;
      REG_STATE:                   return STATE_RST;
      REG_SUB1:                    return SUB1_RST;
      4'hA:                        return SUB2_RST;
      4'hB:                        return SUB3_RST;
      REG_GCALL:                   return GCALL_RST;
      default:                     return 8'h00;
    endcase
  endfunction : fcled_rst_val
endpackage : fcled_pkg

//--- hdl/fcled_top.sv
// Four channel LED PWM driver with a serial-bus slave on its own link clock
// Operation
// - Individual mode: own 256-step PWM per output at 1.5625 kHz, 0 to 99.6 %.
// - Group dimming: own PWM 64 steps at 6.25 kHz, 0 to 98.4 %.
// - One shared 16-step group PWM at 190 Hz dims every group-gated output alike.
// - Blink mode keeps own PWM at 256 steps, 1.5625 kHz.
// - Blink period from 256-step group frequency, 24 Hz down to 10.65 s.
// - Group frequency 6 to 24 Hz: group duty has 64 steps.
// - Group frequency 0.09 to 6 Hz: group duty has 256 steps.
// - Each output is off, on, own PWM, or own PWM gated by group.
// - Push-pull or open-drain selectable; outputs high impedance after reset.
// - Bus soft reset call acts like power-on reset.
// - New settings apply at each acknowledge or at STOP, STOP by default.
// - Answer own, group call and three sub-call addresses.
// - Brightness defaults fully off; group brightness defaults to maximum.
// - Two address pins select the slave address.
// - All timing derives from a 400 kHz internal tick.
// - Serial port works at bus clock rates up to 1 MHz.
// - Soft reset call acknowledged only with write direction.
// - First written byte is the control byte: pointer and advance options.
// - Advance enable set: pointer steps after each byte read or written.
// - Group call enabled and sub-calls disabled after reset.
module fcled_top
  import fcled_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR_BASE = 7'h60,
  parameter bit         USE_ADDR_PINS = 1'b1,
  parameter int         CHANNELS      = 4
)(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                link_clk,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [1:0]          addr_pin_in,
  output logic      [CHANNELS-1:0] drive_output_out,
  output logic      [CHANNELS-1:0] drive_output_oe
);
  if (CHANNELS < 1 || CHANNELS > 4 || OSC_TICK_CYC < 2 || OSC_TICK_CYC > 128)
    $error("fcled_top: unsupported CHANNELS or clock rate");

  localparam logic [6:0] TICK_LAST = 7'(OSC_TICK_CYC - 1);
  localparam int         TICK_A    = OSC_TICK_CYC;

  // Link domain: bus slave and register bank
  logic        rst_m_ff, rst_s_ff;
  logic        scl_m_ff, scl_s_ff, scl_q_ff;
  logic        sda_m_ff, sda_s_ff, sda_q_ff;
  logic [1:0]  apin_m_ff, apin_s_ff;
  fcled_link_e st_ff;
  logic [7:0]  shift_ff;
  logic [3:0]  bit_ff;
  logic [3:0]  ptr_ff;
  logic [2:0]  adv_ff;
  logic        rw_ff, first_ff, sw_ff, sda_oe_ff;
  logic [7:0]  bank_ff [REG_CNT];
  logic [7:0]  snap_ff [CFG_CNT];
  logic        pend_ff, req_ff, ack_m_ff, ack_s_ff;
  logic        ack_ff;

  always_ff @(posedge link_clk)
  begin
    rst_m_ff  <= srst;
    rst_s_ff  <= rst_m_ff;
    scl_m_ff  <= scl_in;
    scl_s_ff  <= scl_m_ff;
    scl_q_ff  <= scl_s_ff;
    sda_m_ff  <= sda_in;
    sda_s_ff  <= sda_m_ff;
    sda_q_ff  <= sda_s_ff;
    apin_m_ff <= addr_pin_in;
    apin_s_ff <= apin_m_ff;
    ack_m_ff  <= ack_ff;
    ack_s_ff  <= ack_m_ff;
  end

  // Oversampled bus lines; the link clock must run well above SCL
  wire scl_rise_w = scl_s_ff & ~scl_q_ff;
  wire scl_fall_w = ~scl_s_ff & scl_q_ff;
  wire start_w    = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
  wire stop_w     = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;
  wire byte_end_w = scl_fall_w && (bit_ff == 4'h8);

  wire [6:0] addr7_w   = shift_ff[7:1];
  wire [6:0] own_w     = USE_ADDR_PINS ? {OWN_ADDR_BASE[6:2], apin_s_ff}
                                       : OWN_ADDR_BASE;
  wire [7:0] mode1_w   = bank_ff[REG_MODE1];
  wire       hit_own_w = (addr7_w == own_w);
  wire       hit_gc_w  = mode1_w[M1_GCALL_EN_BIT]
                         && (addr7_w == bank_ff[REG_GCALL][7:1]);
  wire       hit_sub_w = (mode1_w[M1_SUB1_EN_BIT] && addr7_w == bank_ff[9][7:1])
                         || (mode1_w[M1_SUB1_EN_BIT+1] && addr7_w == bank_ff[10][7:1])
                         || (mode1_w[M1_SUB1_EN_BIT+2] && addr7_w == bank_ff[11][7:1]);
  wire       hit_sw_w  = (addr7_w == SOFT_RESET_ADDR) && !shift_ff[0];
  wire       match_w   = hit_own_w | hit_gc_w | hit_sub_w | hit_sw_w;
  wire       addr_end_w = (st_ff == LK_ADDR) && byte_end_w;
  wire       wr_end_w   = (st_ff == LK_WR) && byte_end_w;
  wire       wr_data_w  = wr_end_w && !first_ff;
  wire       bus_soft_reset_call_w    = (st_ff == LK_ADDR_ACK) && scl_fall_w && sw_ff;
  wire       bank_rst_w = rst_s_ff | bus_soft_reset_call_w;
  wire [3:0] ptr_nxt_w  = (ptr_ff >= REG_LAST) ? 4'h0 : ptr_ff + 4'h1;
  wire [7:0] rdata_w    = (ptr_ff <= REG_LAST) ? bank_ff[ptr_ff] : 8'h00;

  always_ff @(posedge link_clk)
  begin
    if (rst_s_ff)
    begin
      st_ff     <= LK_IDLE;
      shift_ff  <= 8'h00;
      bit_ff    <= 4'h0;
      ptr_ff    <= 4'h0;
      adv_ff    <= 3'h0;
      rw_ff     <= 1'b0;
      first_ff  <= 1'b0;
      sw_ff     <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else if (start_w)
    begin
      st_ff     <= LK_ADDR;
      bit_ff    <= 4'h0;
      sda_oe_ff <= 1'b0;
    end
    else if (stop_w)
    begin
      st_ff     <= LK_IDLE;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      unique case (st_ff)
        LK_IDLE: ;
        LK_ADDR, LK_WR:
          if (scl_rise_w)
          begin
            shift_ff <= {shift_ff[6:0], sda_s_ff};
            bit_ff   <= bit_ff + 4'h1;
          end
          else if (addr_end_w)
          begin
            sda_oe_ff <= match_w;
            rw_ff     <= shift_ff[0];
            sw_ff     <= hit_sw_w;
            st_ff     <= match_w ? LK_ADDR_ACK : LK_IDLE;
          end
          else if (wr_end_w)
          begin
            sda_oe_ff <= 1'b1;
            st_ff     <= LK_WR_ACK;
            if (first_ff)
            begin
              adv_ff <= shift_ff[7:5];
              ptr_ff <= shift_ff[3:0];
            end
            else if (adv_ff[CTRL_ADV_EN_BIT-5])
              ptr_ff <= ptr_nxt_w;
          end
        LK_ADDR_ACK:
          if (scl_fall_w)
          begin
            bit_ff <= rw_ff ? 4'h1 : 4'h0;
            if (sw_ff)
            begin
              sda_oe_ff <= 1'b0;
              st_ff     <= LK_IDLE;
            end
            else if (rw_ff)
            begin
              sda_oe_ff <= ~rdata_w[7];
              shift_ff  <= {rdata_w[6:0], 1'b0};
              st_ff     <= LK_RD;
              if (adv_ff[CTRL_ADV_EN_BIT-5])
                ptr_ff <= ptr_nxt_w;
            end
            else
            begin
              sda_oe_ff <= 1'b0;
              first_ff  <= 1'b1;
              st_ff     <= LK_WR;
            end
          end
        LK_WR_ACK:
          if (scl_fall_w)
          begin
            sda_oe_ff <= 1'b0;
            bit_ff    <= 4'h0;
            first_ff  <= 1'b0;
            st_ff     <= LK_WR;
          end
        LK_RD:
          if (byte_end_w)
          begin
            sda_oe_ff <= 1'b0;
            st_ff     <= LK_RD_ACK;
          end
          else if (scl_fall_w)
          begin
            sda_oe_ff <= ~shift_ff[7];
            shift_ff  <= {shift_ff[6:0], 1'b0};
            bit_ff    <= bit_ff + 4'h1;
          end
        LK_RD_ACK:
          // A master NACK ends the read; ACK fetches the next byte
          if (scl_rise_w)
            st_ff <= sda_s_ff ? LK_IDLE : LK_ADDR_ACK;
      endcase
    end
  end

  always_ff @(posedge link_clk)
  begin
    for (int i = 0; i < REG_CNT; i++)
    begin
      if (bank_rst_w)
        bank_ff[i] <= fcled_rst_val(4'(i));
      else if (wr_data_w && ptr_ff == 4'(i))
        bank_ff[i] <= shift_ff;
    end
  end

  // Applied settings cross by a toggle handshake; the snapshot holds still
  // until the core has taken it, so a late update is deferred, never lost
  wire upd_evt_w = stop_w | (wr_data_w & bank_ff[REG_MODE2][M2_UPD_ACK_BIT]);
  wire idle_w    = (req_ff == ack_s_ff);
  wire copy_w    = pend_ff && idle_w && !bank_rst_w;

  always_ff @(posedge link_clk)
  begin
    if (rst_s_ff)
    begin
      pend_ff <= 1'b1;
      req_ff  <= 1'b0;
    end
    else
    begin
      pend_ff <= upd_evt_w | bank_rst_w | (pend_ff & ~copy_w);
      if (copy_w)
        req_ff <= ~req_ff;
    end
  end

  always_ff @(posedge link_clk)
  begin
    for (int i = 0; i < CFG_CNT; i++)
    begin
      if (rst_s_ff)
        snap_ff[i] <= fcled_rst_val(4'(i + 1));
      else if (copy_w)
        snap_ff[i] <= bank_ff[i + 1];
    end
  end

  always_ff @(posedge link_clk)
  begin
    sda_oe <= sda_oe_ff;
    sda_out <= 1'b0;
  end

  // Core domain: settings, oscillator tick and PWM
  logic        req_m_ff, req_s_ff, req_q_ff;
  logic [7:0]  cfg_ff [CFG_CNT];
  logic [6:0]  div_ff;
  logic        tick_ff;
  logic [7:0]  iph_ff, gph_ff;
  logic [15:0] gdiv_ff;

  wire take_w = req_s_ff ^ req_q_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      req_m_ff <= 1'b0;
      req_s_ff <= 1'b0;
      req_q_ff <= 1'b0;
      ack_ff   <= 1'b0;
    end
    else
    begin
      req_m_ff <= req_ff;
      req_s_ff <= req_m_ff;
      req_q_ff <= req_s_ff;
      if (take_w)
        ack_ff <= req_s_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < CFG_CNT; i++)
    begin
      if (srst)
        cfg_ff[i] <= fcled_rst_val(4'(i + 1));
      else if (take_w)
        cfg_ff[i] <= snap_ff[i];
    end
  end

  wire [7:0]  mode2_w  = cfg_ff[0];
  wire [7:0]  gduty_w  = cfg_ff[5];
  wire [7:0]  gfreq_w  = cfg_ff[6];
  wire [7:0]  state_w  = cfg_ff[7];
  wire        blink_w  = mode2_w[M2_BLINK_BIT];
  wire        pp_w     = mode2_w[M2_PUSHPULL_BIT];
  wire [15:0] glim_w   = blink_w
                         ? 16'(BLINK_STEP_TICKS) * (16'(gfreq_w) + 16'h1) - 16'h1
                         : 16'(GDIM_STEP_TICKS - 1);
  wire        gwrap_w  = tick_ff && (gdiv_ff >= glim_w);
  wire [7:0]  bduty_w  = (gfreq_w <= BLINK_COARSE_MAX) ? (gduty_w & COARSE_MASK)
                                                       : gduty_w;
  wire        grp_on_w = blink_w ? (gph_ff < bduty_w)
                                 : (gph_ff[3:0] < gduty_w[7:4]);

  always_ff @(posedge clk)
  begin
    if (srst || div_ff == TICK_LAST)
      div_ff <= 7'h00;
    else
      div_ff <= div_ff + 7'h01;
    tick_ff <= !srst && (div_ff == TICK_LAST);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      iph_ff  <= 8'h00;
      gph_ff  <= 8'h00;
      gdiv_ff <= 16'h0000;
    end
    else if (tick_ff)
    begin
      iph_ff  <= iph_ff + 8'h01;
      gdiv_ff <= gwrap_w ? 16'h0000 : gdiv_ff + 16'h0001;
      if (gwrap_w)
        gph_ff <= gph_ff + 8'h01;
    end
  end

  logic [CHANNELS-1:0] act_w;

  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_ch
    wire [1:0] sel_w    = state_w[2*c +: 2];
    wire [7:0] bright_w = cfg_ff[1 + c];
    // Coarse period only where the group dimmer gates the output
    wire       coarse_w = !blink_w && (sel_w == OUT_BOTH);
    wire       ind_on_w = coarse_w ? (iph_ff[5:0] < bright_w[7:2])
                                   : (iph_ff < bright_w);
    assign act_w[c] = (sel_w == OUT_ON)
                      || (sel_w == OUT_IND && ind_on_w)
                      || (sel_w == OUT_BOTH && ind_on_w && grp_on_w);

    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        drive_output_oe[c]  <= 1'b0;
        drive_output_out[c] <= 1'b0;
      end
      else
      begin
        // Active output sinks current; open drain lets go when inactive
        drive_output_oe[c]  <= pp_w ? (sel_w != OUT_OFF) : act_w[c];
        drive_output_out[c] <= ~act_w[c];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  tick_period_a: assert property (tick_ff |-> ##TICK_A tick_ff)
    else $error("oscillator tick spacing wrong");
  fine_phase_a: assert property (tick_ff |=> iph_ff == 8'($past(iph_ff) + 8'h01))
    else $error("individual phase did not step on tick");
  zero_duty_a: assert property ((state_w[1:0] == OUT_IND && cfg_ff[1] == 8'h00)
    ##1 (state_w[1:0] == OUT_IND && cfg_ff[1] == 8'h00) |-> drive_output_out[0])
    else $error("zero duty output became active");
  off_hiz_a: assert property ((state_w[1:0] == OUT_OFF) [*2] |-> !drive_output_oe[0])
    else $error("off output still driven");
  full_on_a: assert property ((state_w[1:0] == OUT_ON) [*2]
    |-> drive_output_oe[0] && !drive_output_out[0])
    else $error("on output not sinking");
  dim_step_a: assert property ((!blink_w && gwrap_w) |=> gdiv_ff == 16'h0000
    ##1 (!gwrap_w) [*8])
    else $error("group dimming prescaler wrap wrong");
  cfg_take_a: assert property ($changed(req_s_ff) |=> ack_ff == $past(req_s_ff))
    else $error("settings handshake not answered");

  sequence s_addr_taken;
    addr_end_w && match_w ##1 sda_oe_ff;
  endsequence

  addr_ack_a: assert property (@(posedge link_clk) disable iff (rst_s_ff)
    addr_end_w && match_w |-> s_addr_taken)
    else $error("matched address not acknowledged");
  addr_nack_a: assert property (@(posedge link_clk) disable iff (rst_s_ff)
    addr_end_w && !match_w && !start_w |=> st_ff == LK_IDLE && !sda_oe_ff)
    else $error("unmatched address acknowledged");
  ptr_advance_a: assert property (@(posedge link_clk) disable iff (rst_s_ff)
    wr_data_w && adv_ff[2] && ptr_ff < REG_LAST
    |=> ptr_ff == 4'($past(ptr_ff) + 4'h1))
    else $error("pointer did not advance");
  soft_reset_a: assert property (@(posedge link_clk) disable iff (rst_s_ff)
    bus_soft_reset_call_w |=> bank_ff[REG_MODE1] == MODE1_RST && bank_ff[REG_GDUTY] == GDUTY_RST)
    else $error("soft reset left registers changed");
endmodule : fcled_top

//--- bench/fcled_bus_master.sv
// Serial-bus master model facing the LED driver's slave port
module fcled_bus_master #(
  parameter int QTR = 4
)(
  input  wire logic link_clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock stands high and data is released between frames
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // Quarter bit of four link clocks: a 500 kHz bus, inside the 1 MHz limit
  task automatic qwait();
    repeat (QTR) @(negedge link_clk);
  endtask : qwait

  task automatic start();
    sda_drv = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sda_drv = 1'b0;
    qwait();
    scl = 1'b0;
    qwait();
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sda_drv = 1'b1;
    qwait();
  endtask : stop

  // Data changes only while the clock is low; sampled mid high phase
  task automatic xfer_bit(input logic b, output logic r);
    sda_drv = b;
    qwait();
    scl = 1'b1;
    qwait();
    r = sda_bus;
    qwait();
    scl = 1'b0;
    qwait();
  endtask : xfer_bit

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, ack);
  endtask : wbyte

  task automatic rbyte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(last, r);
  endtask : rbyte
endmodule : fcled_bus_master

//--- bench/testbench.sv
// Self-checking testbench of the four channel LED driver
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcled_pkg::*;

  localparam logic [6:0] OWN_BASE = 7'h60;
  localparam logic [1:0] PINS     = 2'b10;
  localparam logic [7:0] OWN_W    = {OWN_BASE[6:2], PINS, 1'b0};
  localparam int         WIN      = 256 * OSC_TICK_CYC;

  logic       clk;
  logic       srst;
  logic       link_clk;
  logic       scl;
  logic       sda_drv;
  wire  logic sda_bus;
  logic       sda_out;
  logic       sda_oe;
  logic [1:0] addr_pins;
  logic [3:0] dout;
  logic [3:0] doe;
  int         n_mismatch;
  int         cmp_count;
  logic       ack;
  logic [7:0] q[$];
  int         cnt[4];
  logic [7:0] adr_tab[5] = '{8'hC0, 8'hE2, 8'h07, OWN_W, 8'hE0};
  logic       ack_tab[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] def_tab[13] = '{MODE1_RST, MODE2_RST, BRIGHT_RST, BRIGHT_RST, BRIGHT_RST,
                              BRIGHT_RST, GDUTY_RST, GFREQ_RST, STATE_RST, SUB1_RST,
                              SUB2_RST, SUB3_RST, GCALL_RST};

  // Open-drain wire with pull-up: low if either party pulls
  assign sda_bus = sda_drv & ~(sda_oe & ~sda_out);

  fcled_top #(
    .OWN_ADDR_BASE (OWN_BASE)
  ) u_fcled_top (
    .clk              (clk),
    .srst             (srst),
    .link_clk         (link_clk),
    .scl_in           (scl),
    .sda_in           (sda_bus),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .addr_pin_in      (addr_pins),
    .drive_output_out (dout),
    .drive_output_oe  (doe)
  );

  fcled_bus_master u_fcled_bus_master (
    .link_clk (link_clk),
    .sda_bus  (sda_bus),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  initial
  begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // Control byte keeps the unused bit 4 at zero and sets pointer advance
  task automatic reg_wr(input logic [3:0] ptr, input logic [7:0] d[$], input bit do_stop);
    logic a;
    u_fcled_bus_master.start();
    u_fcled_bus_master.wbyte(OWN_W, a);
    `CHK(a, 1'b0)
    u_fcled_bus_master.wbyte({4'h8, ptr}, a);
    `CHK(a, 1'b0)
    foreach (d[i])
    begin
      u_fcled_bus_master.wbyte(d[i], a);
      `CHK(a, 1'b0)
    end
    if (do_stop)
      u_fcled_bus_master.stop();
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] ptr, input int n, output logic [7:0] r[$]);
    logic a;
    logic [7:0] b;
    r = {};
    u_fcled_bus_master.start();
    u_fcled_bus_master.wbyte(OWN_W, a);
    u_fcled_bus_master.wbyte({4'h8, ptr}, a);
    u_fcled_bus_master.start();
    u_fcled_bus_master.wbyte(OWN_W | 8'h01, a);
    `CHK(a, 1'b0)
    for (int i = 0; i < n; i++)
    begin
      u_fcled_bus_master.rbyte(b, i == n - 1);
      r.push_back(b);
    end
    u_fcled_bus_master.stop();
  endtask : reg_rd

  // Address-only frame: expected acknowledge level for one address byte
  task automatic probe(input logic [7:0] adr, input logic exp_ack);
    logic a;
    u_fcled_bus_master.start();
    u_fcled_bus_master.wbyte(adr, a);
    `CHK(a, exp_ack)
    u_fcled_bus_master.stop();
  endtask : probe

  // Updates cross two clock domains, so the wait is bounded, not fixed
  task automatic wait_oe(input logic [3:0] e);
    for (int k = 0; k < 400 && doe !== e; k++)
      @(negedge clk);
  endtask : wait_oe

  // Outputs are sampled mid-cycle, away from the edge that launches them
  task automatic count_active();
    cnt = '{0, 0, 0, 0};
    repeat (WIN)
    begin
      @(negedge clk);
      for (int c = 0; c < 4; c++)
        if (dout[c] === 1'b0)
          cnt[c]++;
        else if (dout[c] !== 1'b1)
          cnt[c] += WIN + 1; // An unknown level spoils that channel's count
    end
  endtask : count_active

  initial
  begin
    // Whole run takes about 82,000 cycles; the margin covers bus latency
    repeat (95000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    n_mismatch = 0;
    cmp_count  = 0;
    srst       = 1'b1;
    addr_pins  = PINS;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (10) @(negedge link_clk);
    `CHK(doe, 4'h0)
    foreach (adr_tab[i])
      probe(adr_tab[i], ack_tab[i]);
    reg_rd(REG_MODE1, REG_CNT, q);
    foreach (def_tab[i])
      `CHK(q[i], def_tab[i])
    // ch0 own at zero, ch1 own at half, ch2 on, ch3 own gated by zero group duty
    reg_wr(REG_BRIGHT, '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'hDA}, 1'b0);
    repeat (50) @(negedge clk);
    `CHK(doe, 4'h0)
    u_fcled_bus_master.stop();
    wait_oe(4'hF);
    `CHK(doe, 4'hF)
    count_active();
    `CHK(cnt[0], 0)
    `CHK(cnt[1], 8'h80 * OSC_TICK_CYC)
    `CHK(cnt[2], WIN)
    `CHK(cnt[3], 0)
    reg_wr(REG_MODE2, '{8'h0C}, 1'b1);
    reg_wr(REG_STATE, '{8'h12}, 1'b0);
    wait_oe(4'h5);
    `CHK(doe, 4'h5)
    u_fcled_bus_master.stop();
    reg_wr(REG_MODE2, '{8'h00}, 1'b1);
    wait_oe(4'h4);
    `CHK(doe, 4'h4)
    `CHK(dout[2], 1'b0)
    u_fcled_bus_master.start();
    u_fcled_bus_master.wbyte({SOFT_RESET_ADDR, 1'b0}, ack);
    `CHK(ack, 1'b0)
    u_fcled_bus_master.stop();
    wait_oe(4'h0);
    `CHK(doe, 4'h0)
    reg_rd(REG_MODE2, 1, q);
    `CHK(q[0], MODE2_RST)
    // Enable the first sub-call, then move the address pins mid-run
    reg_wr(REG_MODE1, '{8'h03}, 1'b1);
    @(negedge clk);
    addr_pins = 2'b01;
    repeat (4) @(negedge link_clk);
    probe(8'hE2, 1'b0);
    probe(8'hE4, 1'b1);
    probe(OWN_W, 1'b1);
    probe({OWN_BASE[6:2], 2'b01, 1'b0}, 1'b0);
    end_of_test();
  end
endmodule : testbench
